// ---- src/adc_ctrl_pkg.sv ----
// Function
// - Busy low during conversion, high with result.
// - Busy falls within 83 ns of start.
// - Result is 16-bit two's complement word.
// - Conversion completes within 4 us.
// - Starts ignored during conversion, reads still allowed.
// - Previous result readable about 3.7 us.
// - New result valid 50 ns before busy rises; the registered data_out shows it 40 ns before.
// - Data driven only when read high, select low.
// - Result readable as word or two bytes.
// - Byte-swap high exchanges upper and lower halves.
// - Select high puts the data outputs high-impedance; busy stays driven.
// - Select fall or read rise enables outputs.
package adc_ctrl_pkg;
	// =====================================================================
	// Timing
	// =====================================================================
	localparam int CLK_PERIOD_NS = 10;
	localparam int START_LOW_NS = 50;
	localparam int START_LOW_CYC = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_DELAY_NS = 83;
	localparam int BUSY_DELAY_CYC = BUSY_DELAY_NS / CLK_PERIOD_NS;
	localparam int CONV_TIME_NS = 4000;
	localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int OLD_VALID_NS = 3700;
	localparam int OLD_VALID_CYC = OLD_VALID_NS / CLK_PERIOD_NS;
	localparam int NEW_LEAD_NS = 50;
	localparam int NEW_LEAD_CYC = (NEW_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 10;
	// =====================================================================
	// Data layout
	// =====================================================================
	localparam int DATA_W = 16;
	localparam int HALF_W = 8;
	localparam logic [DATA_W-1:0] RESULT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
endpackage

// ---- src/adc_conv_if.sv ----
`timescale 1ns/1ps
// Carries the start request from control to the conversion engine, and its completion and code back to control.
interface adc_conv_if;
	logic start;
	logic done;
	logic [15:0] code;
	modport ctrl (output start, input done, input code);
	modport engine (input start, output done, output code);
endinterface

// ---- src/adc_sar_engine.sv ----
`timescale 1ns/1ps
// Conversion engine: counts out the conversion time, then hands over a code.
module adc_sar_engine
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Sampled analog code stand-in
	input wire logic [DATA_W-1:0] sample_code,
	// Control side
	adc_conv_if.engine conv
);
	logic [CNT_W-1:0] cnt_ff;
	logic run_ff;
	logic done_ff;
	logic [DATA_W-1:0] code_ff;
	logic [DATA_W-1:0] held_ff;

	assign conv.done = done_ff;
	assign conv.code = code_ff;

	// =====================================================================
	// Timer
	// =====================================================================
	// The held sample is captured at start so input motion cannot disturb the result.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= CNT_ZERO;
			run_ff <= 1'b0;
			done_ff <= 1'b0;
			code_ff <= RESULT_RST;
			held_ff <= RESULT_RST;
		end else begin
			done_ff <= 1'b0;
			if (conv.start && !run_ff) begin
				run_ff <= 1'b1;
				held_ff <= sample_code;
				cnt_ff <= CNT_ZERO;
			end else if (run_ff) begin
				// Finish early enough that the lead interval and the busy rise still land inside the limit.
				if (cnt_ff == CNT_W'(CONV_CYC - NEW_LEAD_CYC - 3)) begin
					run_ff <= 1'b0;
					done_ff <= 1'b1;
					code_ff <= held_ff;
				end else begin
					cnt_ff <= cnt_ff + 1'b1;
				end
			end
		end
	end
endmodule

// ---- src/adc_parallel_ctrl.sv ----
`timescale 1ns/1ps
// Conversion control and tri-state parallel read-out of the converter.
module adc_parallel_ctrl
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Host control, active low where named
	input wire logic rd_convn,
	input wire logic csn,
	input wire logic byte_swap,
	// Analog front end stand-in
	input wire logic [DATA_W-1:0] sample_code,
	// Status
	output logic busyn,
	// Data bus, result_msb at bit 15 and result_lsb at bit 0 while byte_swap is low
	output logic [DATA_W-1:0] data_out,
	output logic [DATA_W-1:0] data_oe
);
	typedef enum logic [1:0] {IDLE, BUSY, LEAD} state_e;
	// Delay bound for the busy fall, declared here so the check can use it as a range limit.
	localparam int BUSY_WIN = BUSY_DELAY_CYC;

	state_e state_ff;
	logic [CNT_W-1:0] low_cnt_ff;
	logic [CNT_W-1:0] lead_cnt_ff;
	logic [DATA_W-1:0] result_ff;
	logic [CNT_W-1:0] busy_low_cnt_ff;
	logic start_ok;
	logic read_en;
	adc_conv_if conv ();

	// Exchanges the two bytes of a word for the byte-swapped read.
	// Each half goes out whole, so a host reading bytes gets either one in a single access.
	function automatic logic [DATA_W-1:0] swap_halves(input logic [DATA_W-1:0] word);
		return {word[HALF_W-1:0], word[DATA_W-1:HALF_W]};
	endfunction

	// =====================================================================
	// Start detection
	// =====================================================================
	// Inputs are combined as an AND of the two lows; width is measured in cycles.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			low_cnt_ff <= CNT_ZERO;
		end else if (rd_convn || csn) begin
			low_cnt_ff <= CNT_ZERO;
		end else if (low_cnt_ff != CNT_W'(START_LOW_CYC)) begin
			low_cnt_ff <= low_cnt_ff + 1'b1;
		end
	end

	// A start fires once per low period, when it reaches the minimum width.
	assign start_ok = (low_cnt_ff == CNT_W'(START_LOW_CYC - 1)) && !rd_convn && !csn;
	assign conv.start = start_ok && (state_ff == IDLE);

	adc_sar_engine u_engine (
		.clk(clk),
		.resetn(resetn),
		.sample_code(sample_code),
		.conv(conv)
	);

	// =====================================================================
	// Busy sequencing
	// =====================================================================
	// LEAD holds busy low for the interval where new data already shows.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= IDLE;
			lead_cnt_ff <= CNT_ZERO;
		end else begin
			case (state_ff)
				IDLE: begin
					if (conv.start) begin
						state_ff <= BUSY;
					end
				end
				BUSY: begin
					if (conv.done) begin
						state_ff <= LEAD;
						lead_cnt_ff <= CNT_ZERO;
					end
				end
				LEAD: begin
					if (lead_cnt_ff == CNT_W'(NEW_LEAD_CYC - 1)) begin
						state_ff <= IDLE;
					end else begin
						lead_cnt_ff <= lead_cnt_ff + 1'b1;
					end
				end
				default: begin
					state_ff <= IDLE;
				end
			endcase
		end
	end

	// Busy falls the cycle after start, well inside the allowed delay.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busyn <= 1'b1;
		end else if (conv.start) begin
			busyn <= 1'b0;
		end else if (state_ff == LEAD && lead_cnt_ff == CNT_W'(NEW_LEAD_CYC - 1)) begin
			busyn <= 1'b1;
		end
	end

	// =====================================================================
	// Output register
	// =====================================================================
	// Old result stays until done; the new word lands before busy rises.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			result_ff <= RESULT_RST;
		end else if (conv.done) begin
			result_ff <= conv.code;
		end
	end

	// Busy-low time in cycles; only the checks read it, to bound how long old data stands.
	// It saturates so a stuck busy cannot wrap it back into the legal range.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy_low_cnt_ff <= CNT_ZERO;
		end else if (busyn) begin
			busy_low_cnt_ff <= CNT_ZERO;
		end else if (busy_low_cnt_ff != {CNT_W{1'b1}}) begin
			busy_low_cnt_ff <= busy_low_cnt_ff + 1'b1;
		end
	end

	// Output enable follows the level of both inputs, which covers both enabling edges.
	assign read_en = rd_convn && !csn;

	// Drivers are registered, so the bus lags the select lines by one cycle.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_out <= RESULT_RST;
			data_oe <= RESULT_RST;
		end else begin
			data_oe <= {DATA_W{read_en}};
			if (byte_swap) begin
				data_out <= swap_halves(result_ff);
			end else begin
				data_out <= result_ff;
			end
		end
	end

	// =====================================================================
	// Checks
	// =====================================================================
	// Start acceptance and the busy-low timing around it.
	busy_fall_a: assert property (@(posedge clk) disable iff (!resetn)
		conv.start |=> !busyn)
		else $error("busy did not fall after start");
	busy_window_a: assert property (@(posedge clk) disable iff (!resetn)
		conv.start |-> ##[1:BUSY_WIN] !busyn)
		else $error("busy fell too late after start");
	busy_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		$fell(busyn) |=> !busyn [*8])
		else $error("busy rose too early");
	conv_time_a: assert property (@(posedge clk) disable iff (!resetn)
		conv.start |-> ##[1:400] $rose(busyn))
		else $error("conversion exceeded limit");
	start_width_a: assert property (@(posedge clk) disable iff (!resetn)
		conv.start |-> $past(!rd_convn && !csn, 4))
		else $error("start without full low width");
	start_once_a: assert property (@(posedge clk) disable iff (!resetn)
		conv.start |=> !start_ok)
		else $error("second start in one low period");

	// A start seen outside idle must not keep busy low past the lead interval.
	ignore_start_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == LEAD) && (lead_cnt_ff == CNT_W'(NEW_LEAD_CYC - 1)) |=> busyn && (state_ff == IDLE))
		else $error("lead end did not release busy");

	// State and busy must agree at every edge.
	busy_state_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == BUSY) |-> !busyn)
		else $error("busy high during conversion");
	idle_busy_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == IDLE) |-> busyn)
		else $error("busy low while idle");
	done_busy_a: assert property (@(posedge clk) disable iff (!resetn)
		conv.done |-> !busyn)
		else $error("result arrived with busy high");
	busy_rise_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(busyn) |-> ($past(state_ff) == LEAD))
		else $error("busy rose outside the lead interval");

	// Result register: old word stands, new word lands ahead of busy.
	lead_data_a: assert property (@(posedge clk) disable iff (!resetn)
		conv.done |=> (result_ff == $past(conv.code)) && !busyn ##5 busyn)
		else $error("new data not ahead of busy rise");
	lead_code_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == LEAD) |-> (result_ff == conv.code))
		else $error("new word missing during lead");
	hold_result_a: assert property (@(posedge clk) disable iff (!resetn)
		!conv.done |=> $stable(result_ff))
		else $error("result changed without conversion");
	old_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		conv.done |-> (busy_low_cnt_ff >= CNT_W'(OLD_VALID_CYC)))
		else $error("old result replaced too early");

	// Bus drive and byte order, one cycle behind the select lines.
	hiz_select_a: assert property (@(posedge clk) disable iff (!resetn)
		csn |=> (data_oe == 16'h0000))
		else $error("bus driven while deselected");
	drive_read_a: assert property (@(posedge clk) disable iff (!resetn)
		(rd_convn && !csn) |=> (data_oe == 16'hFFFF))
		else $error("bus not driven during read");
	read_gate_a: assert property (@(posedge clk) disable iff (!resetn)
		!(rd_convn && !csn) |=> (data_oe == 16'h0000))
		else $error("bus driven outside a read");
	swap_bytes_a: assert property (@(posedge clk) disable iff (!resetn)
		(byte_swap && !conv.done) |=> (data_out == {result_ff[7:0], result_ff[15:8]}))
		else $error("byte swap wrong");
	word_order_a: assert property (@(posedge clk) disable iff (!resetn)
		(!byte_swap && !conv.done) |=> (data_out == result_ff))
		else $error("word order wrong");
endmodule

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
// =====================================================================
// Host model
// =====================================================================
// Host processor on the parallel bus; pins change just after a falling edge.
module host_model (
	// Clock
	input wire logic clk,
	// Control pins toward the converter
	output logic rd_convn,
	output logic csn,
	output logic byte_swap
);
	// Deselected at start so reset never sees a start request.
	initial begin
		rd_convn = 1'b1;
		csn = 1'b1;
		byte_swap = 1'b0;
	end
	// Start request held cyc cycles; tied_cs keeps the select low throughout.
	task automatic convert(input bit tied_cs, input int cyc);
		@(negedge clk);
		rd_convn = 1'b0;
		if (!tied_cs) begin
			csn = 1'b1;
			@(negedge clk);
		end
		csn = 1'b0;
		repeat (cyc) @(negedge clk);
		rd_convn = 1'b1;
		if (!tied_cs) csn = 1'b1;
	endtask
	// Read access; read stays high and select low until the next task changes them.
	task automatic read(input logic bs);
		@(negedge clk);
		rd_convn = 1'b1;
		csn = 1'b0;
		byte_swap = bs;
	endtask
	// Release the bus so the outputs float.
	task automatic release_bus();
		@(negedge clk);
		csn = 1'b1;
	endtask
endmodule

// ---- tb/test_adc_parallel_conversion_control.sv ----
`timescale 1ns/1ps
// =====================================================================
// Testbench
// =====================================================================
module test_adc_parallel_conversion_control;
	import adc_ctrl_pkg::*;
	logic clk, resetn, rd_convn, csn, byte_swap, busyn;
	logic [DATA_W-1:0] sample_code, data_out, data_oe;
	int err_count, tests_run, cycles;
	host_model host_model_i (.clk, .rd_convn, .csn, .byte_swap);
	adc_parallel_ctrl adc_parallel_ctrl_i (.clk, .resetn, .rd_convn, .csn, .byte_swap, .sample_code,
		.busyn, .data_out, .data_oe);
	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// A hang counts as a mismatch and still reaches the verdict.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			err_count++;
		end
	endtask
	// Bounded wait for busy to reach lvl, then judge it.
	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (busyn !== lvl && n < lim) begin
			@(negedge clk);
			n++;
		end
		check("busyn", {15'h0000, busyn}, {15'h0000, lvl});
	endtask
	// One conversion; poke retries a start mid-conversion, which must be ignored.
	task automatic do_conv(input bit tied, input logic [15:0] code, input logic [15:0] prev, input bit poke);
		sample_code = code;
		host_model_i.convert(tied, 5);
		wait_busy(1'b0, 3);
		sample_code = ~code;
		if (poke) host_model_i.convert(1'b1, 6);
		host_model_i.read(1'b0);
		repeat (2) @(negedge clk);
		check("old data", data_out, prev);
		check("oe", data_oe, 16'hFFFF);
		wait_busy(1'b1, 400);
		check("new data", data_out, code);
		repeat (20) @(negedge clk);
		check("no restart", {15'h0000, busyn}, 16'h0001);
		$display("Conversion of %h done", code);
	endtask
	// Byte order, float on deselect, and a too-short start pulse.
	task automatic t_read(input logic [15:0] code);
		host_model_i.read(1'b1);
		repeat (2) @(negedge clk);
		check("swapped", data_out, {code[7:0], code[15:8]});
		host_model_i.read(1'b0);
		repeat (2) @(negedge clk);
		check("word", data_out, code);
		host_model_i.release_bus();
		repeat (2) @(negedge clk);
		check("float", data_oe, 16'h0000);
		host_model_i.convert(1'b0, 3);
		repeat (10) @(negedge clk);
		check("short", {15'h0000, busyn}, 16'h0001);
		host_model_i.read(1'b0);
		repeat (2) @(negedge clk);
		check("held", data_out, code);
		$display("Read test done");
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Reset, then the scenarios in order.
	initial begin
		resetn = 1'b0;
		sample_code = 16'h0000;
		repeat (4) @(negedge clk);
		check("reset busy", {15'h0000, busyn}, 16'h0001);
		check("reset oe", data_oe, 16'h0000);
		resetn = 1'b1;
		do_conv(1'b1, 16'h8001, 16'h0000, 1'b0);
		t_read(16'h8001);
		do_conv(1'b0, 16'h1234, 16'h8001, 1'b1);
		t_read(16'h1234);
		finish_test();
	end
endmodule
